/* File: logic/scpi_kw_match.sv */
`timescale 1ns/10ps
module scpi_kw_match
  import scpi_pkg::*;
#(
  parameter int N = KW_N
) (
  input wire logic [KW_BITS-1:0] buf_i,
  input wire logic [3:0] len_i,
  output logic [4:0] id_o,
  output logic hit_o
);

  logic [N:1] hit;

  generate
    for (genvar k = 1; k <= N; k++) begin : g_kw
      logic [KW_BITS-1:0] short_form;
      assign short_form = KW_TABLE[k].text
        >> (8 * (KW_TABLE[k].long_len - KW_TABLE[k].short_len));
      assign hit[k] = (len_i == KW_TABLE[k].long_len && buf_i == KW_TABLE[k].text)
        || (len_i == KW_TABLE[k].short_len && buf_i == short_form);
    end
  endgenerate

  // Lowest index wins; forms are unique so at most one hits
  always_comb begin
    id_o = 5'h00;
    for (int k = N; k >= 1; k--) begin
      if (hit[k]) begin
        id_o = 5'(k);
      end
    end
    hit_o = |hit;
  end

endmodule

/* File: logic/scpi_parser.sv */
`timescale 1ns/10ps
// Behaviour
// - Messages are 7-bit ASCII characters; bytes with bit 7 set are taken inside quoted strings
// - Codes 0-9 and 11-32 are white space
// - Question mark after header means query
// - Asterisk header is a common command
// - Single top keyword selects a subsystem
// - Colons separate keywords from top down
// - Keyword meaning depends on path position
// - Optional keywords may appear or be omitted
// - Only exact short or long form
// - Upper and lower case are equal
// - Commas separate parameters, kept in order
// - Minimum, maximum, default accepted as values; only the first parameter's is reported
// - Numeric suffix selects; none means one
// - Line ends on newline or end-or-identify
// - Semicolons separate commands in a line
// - Semicolon then colon restarts at top
// - Bare semicolon continues below shared levels
// - New line clears the path context
module scpi_parser
  import scpi_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire char_t CHAR_I,
  output cmd_t CMD_O,
  output par_t PAR_O
);

  typedef struct packed {
    state_t state;
    logic [KW_BITS-1:0] kbuf;
    logic [3:0] klen;
    logic [4:0] cur;
    logic [4:0] base;
    logic [7:0] suffix;
    logic suf_seen;
    logic digs;
    logic query;
    logic common;
    logic err;
    logic [3:0] pcount;
    logic pany;
    logic [1:0] special;
    logic quote;
    logic [7:0] qchar;
    cmd_t cmd;
    par_t par;
  } st_t;

  st_t r_reg;
  st_t r_next;
  logic [7:0] ch;
  logic [7:0] up;
  logic is_alpha;
  logic is_digit;
  logic is_ws;
  logic is_nl;
  logic eol;
  logic app_ok;
  logic [KW_BITS-1:0] mbuf;
  logic [3:0] mlen;
  logic [4:0] kw_id;
  logic kw_hit;
  logic [NODE_N:1] node_hit;
  logic [4:0] node_id;
  logic node_ok;
  logic [4:0] res_node;
  logic res_ok;
  logic [1:0] spec;

  // Character classes
  assign ch = CHAR_I.data;
  assign up = (ch >= CH_LO_A && ch <= CH_LO_Z) ? ch - CASE_GAP : ch;
  assign is_alpha = up >= CH_UP_A && up <= CH_UP_Z;
  assign is_digit = ch >= CH_DIG_0 && ch <= CH_DIG_9;
  assign is_ws = ch <= CH_WS_LO || (ch > CH_NL && ch <= CH_WS_HI);
  // newline or end-or-identify closes the line
  assign is_nl = ch == CH_NL;
  assign eol = is_nl || CHAR_I.eoi;

  // Token with this byte appended, so a last byte with EOI still resolves
  assign app_ok = is_alpha && !r_reg.quote && r_reg.klen != KLEN_MAX
    && (r_reg.state == S_START || r_reg.state == S_PARAM
    || (r_reg.state == S_KEY && !r_reg.digs));
  assign mbuf = app_ok ? {r_reg.kbuf[KW_BITS-9:0], up} : r_reg.kbuf;
  assign mlen = app_ok ? r_reg.klen + 4'h1 : r_reg.klen;

  scpi_kw_match #(
    .N(KW_N)
  ) u_match (
    .buf_i(mbuf),
    .len_i(mlen),
    .id_o(kw_id),
    .hit_o(kw_hit)
  );

  // keyword looked up under the current parent only
  generate
    for (genvar j = 1; j <= NODE_N; j++) begin : g_node
      assign node_hit[j] = kw_hit && NODE_TABLE[j].parent == r_reg.cur
        && NODE_TABLE[j].kw == kw_id;
    end
  endgenerate

  // top keywords are children of the root node
  always_comb begin
    node_id = ROOT;
    node_ok = 1'b0;
    for (int j = NODE_N; j >= 1; j--) begin
      if (node_hit[j]) begin
        node_id = 5'(j);
        node_ok = 1'b1;
      end
    end
  end

  // common headers resolve to their own keyword code
  assign res_node = r_reg.common ? kw_id : node_id;
  assign res_ok = r_reg.common ? (kw_hit && kw_id >= KW_RST) : node_ok;

  // symbolic values in place of a number
  always_comb begin
    spec = SP_NONE;
    if (kw_hit && kw_id == KW_MIN) begin
      spec = SP_MIN;
    end else if (kw_hit && kw_id == KW_MAX) begin
      spec = SP_MAX;
    end else if (kw_hit && kw_id == KW_DEF) begin
      spec = SP_DEF;
    end
  end

  // Close one command: report it and prepare the next one
  function automatic st_t finish(input st_t s, input logic [4:0] node,
                                 input logic bad, input logic eol_f);
    st_t f;
    logic [4:0] code;
    logic e;
    // Per-command fields clear; S_START and SP_NONE both encode as zero
    f = '0;
    f.par = s.par;
    // optional levels carry the function of their parent
    code = s.common ? node : NODE_TABLE[node].func;
    // a bare path prefix has no function and is refused too
    e = bad || s.err || code == F_NONE;
    f.cmd.valid = 1'b1;
    f.cmd.err = e;
    f.cmd.query = s.query;
    f.cmd.common = s.common;
    f.cmd.code = e ? F_NONE : code;
    f.cmd.suffix = s.suf_seen ? s.suffix : SUFFIX_DEFAULT;
    f.cmd.nparams = s.pany ? s.pcount + 4'h1 : 4'h0;
    f.cmd.special = s.special;
    // keep levels shared with this command; errors keep the old ones
    f.base = (!e && !s.common) ? NODE_TABLE[node].parent : s.base;
    // a fresh line decodes from the top again
    if (eol_f) begin
      f.base = ROOT;
    end
    f.cur = f.base;
    return f;
  endfunction

  // Byte-wise parse, one byte per enabled cycle
  always_comb begin
    r_next = r_reg;
    r_next.cmd.valid = 1'b0;
    r_next.par.valid = 1'b0;
    if (CHAR_I.valid) begin
      if (ch[7] && !r_reg.quote) begin
        r_next.err = 1'b1;
        r_next.state = S_SKIP;
      end else begin
        case (r_reg.state)
          S_START: begin
            if (ch == CH_COLON) begin
              // leading colon restarts from the top level
              r_next.cur = ROOT;
            end else if (ch == CH_STAR) begin
              r_next.common = 1'b1;
              r_next.state = S_KEY;
            end else if (app_ok) begin
              r_next.kbuf = mbuf;
              r_next.klen = mlen;
              r_next.state = S_KEY;
            end else if (!(is_ws || is_nl || ch == CH_SEMI)) begin
              r_next.err = 1'b1;
              r_next.state = S_SKIP;
            end
          end
          S_KEY: begin
            if (app_ok) begin
              r_next.kbuf = mbuf;
              r_next.klen = mlen;
            end else if (is_digit && !r_reg.common && r_reg.klen != 4'h0) begin
              // decimal suffix; digits of every keyword in the header run on into one number
              r_next.suffix = 8'(r_reg.suffix * SUFFIX_RADIX + (ch - CH_DIG_0));
              r_next.suf_seen = 1'b1;
              r_next.digs = 1'b1;
            end else if (ch == CH_COLON && !r_reg.common) begin
              // colon steps one level down the path
              if (node_ok) begin
                r_next.cur = node_id;
                r_next.kbuf = '0;
                r_next.klen = 4'h0;
                r_next.digs = 1'b0;
              end else begin
                r_next.err = 1'b1;
                r_next.state = S_SKIP;
              end
            end else if (ch == CH_QUERY || is_ws) begin
              // question mark right after the header
              if (res_ok) begin
                r_next.cur = res_node;
                r_next.query = ch == CH_QUERY;
                r_next.state = (ch == CH_QUERY) ? S_QUERY : S_PARAM;
                r_next.kbuf = '0;
                r_next.klen = 4'h0;
              end else begin
                r_next.err = 1'b1;
                r_next.state = S_SKIP;
              end
            end else if (ch == CH_SEMI) begin
              // semicolon closes the command; with EOI the line too
              r_next = finish(r_next, res_node, !res_ok, eol);
            end else if (!is_nl) begin
              r_next.err = 1'b1;
              r_next.state = S_SKIP;
            end
          end
          S_QUERY: begin
            if (is_ws) begin
              r_next.state = S_PARAM;
            end else if (ch == CH_SEMI) begin
              r_next = finish(r_next, r_reg.cur, 1'b0, eol);
            end else if (!is_nl) begin
              r_next.err = 1'b1;
              r_next.state = S_SKIP;
            end
          end
          S_PARAM: begin
            if (r_reg.quote) begin
              // Strings pass whole; separators inside are data
              r_next.par = '{valid: 1'b1, data: ch, index: r_reg.pcount};
              r_next.quote = ch != r_reg.qchar;
            end else if (ch == CH_DQUOTE || ch == CH_SQUOTE) begin
              r_next.par = '{valid: 1'b1, data: ch, index: r_reg.pcount};
              r_next.quote = 1'b1;
              r_next.qchar = ch;
              r_next.pany = 1'b1;
            end else if (ch == CH_COMMA) begin
              // next parameter, index counts up in order
              if (r_reg.pcount == 4'h0) begin
                r_next.special = spec;
              end
              r_next.pcount = r_reg.pcount + 4'h1;
              r_next.pany = 1'b1;
              r_next.kbuf = '0;
              r_next.klen = 4'h0;
            end else if (ch == CH_SEMI) begin
              if (r_reg.pcount == 4'h0) begin
                r_next.special = spec;
              end
              r_next = finish(r_next, r_reg.cur, 1'b0, eol);
            end else if (!is_ws && !is_nl) begin
              r_next.par = '{valid: 1'b1, data: ch, index: r_reg.pcount};
              r_next.pany = 1'b1;
              r_next.kbuf = mbuf;
              r_next.klen = mlen;
            end
          end
          S_SKIP: begin
            // rest of a bad command is dropped
            if (ch == CH_SEMI) begin
              r_next = finish(r_next, ROOT, 1'b1, eol);
            end
          end
          default: begin
            r_next.state = S_START;
          end
        endcase
      end
      // end of line also closes any open command
      if (eol && !r_next.cmd.valid) begin
        case (r_next.state)
          S_START: begin
            // empty line still resets the path
            r_next.cur = ROOT;
            r_next.base = ROOT;
          end
          S_KEY: begin
            r_next = finish(r_next, res_node, !res_ok || r_next.klen == 4'h0, 1'b1);
          end
          S_QUERY: begin
            r_next = finish(r_next, r_next.cur, 1'b0, 1'b1);
          end
          S_PARAM: begin
            if (r_next.pcount == 4'h0 && !r_next.quote) begin
              r_next.special = spec;
            end
            r_next = finish(r_next, r_next.cur, 1'b0, 1'b1);
          end
          default: begin
            r_next = finish(r_next, ROOT, 1'b1, 1'b1);
          end
        endcase
      end
    end
  end

  // State register; enable low freezes everything, outputs included
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      r_reg <= '0;
    end else if (CE_I) begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from flip-flops
  assign CMD_O = r_reg.cmd;
  assign PAR_O = r_reg.par;

endmodule

/* File: logic/scpi_pkg.sv */
package scpi_pkg;

  // Token buffer and table sizes
  localparam int KW_CHARS = 12;
  localparam int KW_BITS = 8 * KW_CHARS;
  localparam int KW_N = 26;
  localparam int NODE_N = 22;
  localparam logic [3:0] KLEN_MAX = 4'hc;

  // ASCII codes the parser reacts to
  localparam logic [7:0] CH_WS_LO = 8'h09;
  localparam logic [7:0] CH_NL = 8'h0a;
  localparam logic [7:0] CH_WS_HI = 8'h20;
  localparam logic [7:0] CH_DQUOTE = 8'h22;
  localparam logic [7:0] CH_SQUOTE = 8'h27;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_DIG_0 = 8'h30;
  localparam logic [7:0] CH_DIG_9 = 8'h39;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_QUERY = 8'h3f;
  localparam logic [7:0] CH_UP_A = 8'h41;
  localparam logic [7:0] CH_UP_Z = 8'h5a;
  localparam logic [7:0] CH_LO_A = 8'h61;
  localparam logic [7:0] CH_LO_Z = 8'h7a;
  localparam logic [7:0] CASE_GAP = 8'h20;

  // Suffix handling and path root
  localparam logic [7:0] SUFFIX_DEFAULT = 8'h01;
  localparam logic [7:0] SUFFIX_RADIX = 8'h0a;
  localparam logic [4:0] ROOT = 5'h00;

  // Symbolic parameter codes
  localparam logic [1:0] SP_NONE = 2'h0;
  localparam logic [1:0] SP_MIN = 2'h1;
  localparam logic [1:0] SP_MAX = 2'h2;
  localparam logic [1:0] SP_DEF = 2'h3;

  // Keyword identities, index into the keyword table
  typedef enum logic [4:0] {
    KW_NONE = 5'h00, KW_SYST, KW_BEEP, KW_STAT, KW_MMEM, KW_DATA, KW_LENG,
    KW_DCAT, KW_OUTP, KW_MARK, KW_LIST, KW_SOUR, KW_CLOC, KW_I, KW_FILT,
    KW_LOAD, KW_MSIS, KW_AMPL, KW_MIN, KW_MAX, KW_DEF, KW_RST, KW_CLS,
    KW_ESE, KW_ESR, KW_IDN, KW_OPC
  } kw_id_t;

  // Function codes for complete device-specific headers
  typedef enum logic [4:0] {
    F_NONE = 5'h00, F_BEEP_STATE, F_DATA_LEN, F_DCAT_LEN, F_LOAD, F_MSIS,
    F_MARK_LIST, F_I_MODE, F_I_STATE, F_I_AMPL, F_FILTER, F_CLOCK
  } func_t;

  // Long form right-aligned; short form is its leading part
  typedef struct packed {
    logic [KW_BITS-1:0] text;
    logic [3:0] short_len;
    logic [3:0] long_len;
  } kw_entry_t;

  localparam kw_entry_t KW_TABLE [1:KW_N] = '{
    '{96'("SYSTEM"), 4'h4, 4'h6},
    '{96'("BEEPER"), 4'h4, 4'h6},
    '{96'("STATE"), 4'h4, 4'h5},
    '{96'("MMEMORY"), 4'h4, 4'h7},
    '{96'("DATA"), 4'h4, 4'h4},
    '{96'("LENGTH"), 4'h4, 4'h6},
    '{96'("DCATALOG"), 4'h4, 4'h8},
    '{96'("OUTPUT"), 4'h4, 4'h6},
    '{96'("MARKER"), 4'h4, 4'h6},
    '{96'("LIST"), 4'h4, 4'h4},
    '{96'("SOURCE"), 4'h4, 4'h6},
    '{96'("CLOCK"), 4'h4, 4'h5},
    '{96'("I"), 4'h1, 4'h1},
    '{96'("FILTER"), 4'h4, 4'h6},
    '{96'("LOAD"), 4'h4, 4'h4},
    '{96'("MSIS"), 4'h4, 4'h4},
    '{96'("AMPLITUDE"), 4'h4, 4'h9},
    '{96'("MINIMUM"), 4'h3, 4'h7},
    '{96'("MAXIMUM"), 4'h3, 4'h7},
    '{96'("DEFAULT"), 4'h3, 4'h7},
    '{96'("RST"), 4'h3, 4'h3},
    '{96'("CLS"), 4'h3, 4'h3},
    '{96'("ESE"), 4'h3, 4'h3},
    '{96'("ESR"), 4'h3, 4'h3},
    '{96'("IDN"), 4'h3, 4'h3},
    '{96'("OPC"), 4'h3, 4'h3}
  };

  // Command tree; optional levels repeat the function of their parent
  typedef struct packed {
    logic [4:0] parent;
    kw_id_t kw;
    func_t func;
  } node_t;

  localparam node_t NODE_TABLE [0:NODE_N] = '{
    '{5'h00, KW_NONE, F_NONE},
    '{5'h00, KW_SYST, F_NONE},
    '{5'h01, KW_BEEP, F_NONE},
    '{5'h02, KW_STAT, F_BEEP_STATE},
    '{5'h00, KW_MMEM, F_NONE},
    '{5'h04, KW_DATA, F_NONE},
    '{5'h05, KW_LENG, F_DATA_LEN},
    '{5'h04, KW_DCAT, F_NONE},
    '{5'h07, KW_LENG, F_DCAT_LEN},
    '{5'h04, KW_LOAD, F_LOAD},
    '{5'h04, KW_MSIS, F_MSIS},
    '{5'h00, KW_OUTP, F_NONE},
    '{5'h0b, KW_MARK, F_MARK_LIST},
    '{5'h0c, KW_LIST, F_MARK_LIST},
    '{5'h0b, KW_I, F_I_MODE},
    '{5'h0e, KW_STAT, F_I_STATE},
    '{5'h0e, KW_AMPL, F_I_AMPL},
    '{5'h0b, KW_FILT, F_FILTER},
    '{5'h00, KW_SOUR, F_NONE},
    '{5'h12, KW_CLOC, F_CLOCK},
    '{5'h00, KW_CLOC, F_CLOCK},
    '{5'h00, KW_MARK, F_MARK_LIST},
    '{5'h15, KW_LIST, F_MARK_LIST}
  };

  typedef enum logic [2:0] {
    S_START = 3'b000,
    S_KEY = 3'b001,
    S_QUERY = 3'b010,
    S_PARAM = 3'b011,
    S_SKIP = 3'b100
  } state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic eoi;
  } char_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic [3:0] index;
  } par_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic query;
    logic common;
    logic [4:0] code;
    logic [7:0] suffix;
    logic [3:0] nparams;
    logic [1:0] special;
  } cmd_t;

endpackage

/* File: verif/ctrl_model.sv */
`timescale 1ns/10ps
module ctrl_model
  import scpi_pkg::*;
(
  input wire logic clk_i,
  output logic ce_o,
  output char_t char_o
);
  initial begin
    ce_o = 1'b1;
    char_o = '0;
  end

  // ASCII bytes, end-or-identify optional on the last one
  task automatic send(input string s, input bit eoi_last, input int stall_at);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clk_i);
      char_o <= '{1'b1, s[i], eoi_last && (i == s.len() - 1)};
      // Stall the receiver while a byte waits, to prove nothing is lost
      if (i == stall_at) begin
        ce_o <= 1'b0;
        repeat (3) @(negedge clk_i);
        ce_o <= 1'b1;
      end
    end
    // Released bus shows the inverse so a stale byte cannot pass
    @(negedge clk_i);
    char_o <= '{1'b0, ~s[s.len()-1], 1'b0};
  endtask
endmodule

/* File: verif/scpi_checker.sv */
`timescale 1ns/10ps
module scpi_checker
  import scpi_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire char_t CHAR_I,
  input wire cmd_t CMD_O,
  input wire par_t PAR_O
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);

  // Report pulse consumed by an enabled edge
  sequence s_cmd_taken;
    CMD_O.valid && CE_I;
  endsequence

  a_cmd_one_cycle: assert property (s_cmd_taken |=> !CMD_O.valid)
    else $error("command pulse longer than one cycle");
  a_cmd_cause: assert property (CMD_O.valid && $past(CE_I) |->
    $past(CHAR_I.valid && (CHAR_I.data == CH_SEMI || CHAR_I.data == CH_NL || CHAR_I.eoi)))
    else $error("command reported without a terminator byte");
  a_par_cause: assert property (PAR_O.valid && $past(CE_I) |->
    $past(CHAR_I.valid) && PAR_O.data == $past(CHAR_I.data))
    else $error("parameter byte not the byte taken before");
  // Frozen enable must hold every output, pulses included
  a_freeze_hold: assert property (!CE_I |=> $stable(CMD_O) && $stable(PAR_O))
    else $error("outputs moved while enable low");
  a_err_no_code: assert property (CMD_O.valid && CMD_O.err |-> CMD_O.code == F_NONE)
    else $error("rejected command carries a function");
  a_common_code: assert property (CMD_O.valid && CMD_O.common && !CMD_O.err |->
    CMD_O.code inside {[KW_RST:KW_OPC]})
    else $error("common command code out of range");
  a_special_none: assert property (CMD_O.valid && CMD_O.nparams == 4'h0 |->
    CMD_O.special == SP_NONE)
    else $error("symbolic value reported without parameters");
  a_common_suffix: assert property (CMD_O.valid && CMD_O.common && !CMD_O.err |->
    CMD_O.suffix == SUFFIX_DEFAULT)
    else $error("common command with a suffix other than one");
endmodule

bind scpi_parser scpi_checker i_scpi_checker (
  .CLK_SYS_I(CLK_SYS_I),
  .RST_I(RST_I),
  .CE_I(CE_I),
  .CHAR_I(CHAR_I),
  .CMD_O(CMD_O),
  .PAR_O(PAR_O)
);

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top;
  import scpi_pkg::*;
  logic clk_sys_i;
  logic rst_i;
  logic ce_i;
  char_t char_i;
  cmd_t cmd_o;
  par_t par_o;
  int error_cnt = 0;
  int n_tests = 0;
  cmd_t cq[$];
  logic [7:0] pq[$];
  logic [3:0] iq[$];

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  scpi_parser i_scpi_parser (.CLK_SYS_I(clk_sys_i), .RST_I(rst_i), .CE_I(ce_i),
    .CHAR_I(char_i), .CMD_O(cmd_o), .PAR_O(par_o));
  ctrl_model i_ctrl_model (.clk_i(clk_sys_i), .ce_o(ce_i), .char_o(char_i));

  // Collect pulses at the edge that consumes them, once each
  always @(posedge clk_sys_i) begin
    if (ce_i === 1'b1 && cmd_o.valid === 1'b1) cq.push_back(cmd_o);
    if (ce_i === 1'b1 && par_o.valid === 1'b1) begin
      pq.push_back(par_o.data);
      iq.push_back(par_o.index);
    end
  end

  function automatic cmd_t mk(logic [4:0] code, logic q, logic cm, logic er,
      logic [7:0] sf, logic [3:0] np, logic [1:0] sp);
    return '{1'b1, er, q, cm, code, sf, np, sp};
  endfunction

  task automatic results();
    $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic line(input string s, input bit eoi, input int stall_at);
    pq.delete();
    iq.delete();
    cq.delete();
    i_ctrl_model.send(s, eoi, stall_at);
  endtask

  // Pop one report, bounded wait
  task automatic expect_cmd(input string nm, input cmd_t e);
    cmd_t got;
    int n;
    n = 0;
    while (cq.size() == 0 && n < 40) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (cq.size() == 0) begin
      error_cnt++;
      $display("MISMATCH %s exp pulse got none", nm);
      results();
    end else begin
      got = cq.pop_front();
      `CHK(nm, e, got)
    end
  endtask

  task automatic expect_bytes(input string nm, input string s);
    `CHK(nm, s.len(), pq.size())
    for (int i = 0; i < s.len() && i < pq.size(); i++) `CHK(nm, s[i], pq[i])
    pq.delete();
  endtask

  task automatic t_common();
    line("*RST\n", 1'b0, -1);
    expect_cmd("rst", mk(KW_RST, 1'b0, 1'b1, 1'b0, 8'h01, 4'h0, SP_NONE));
    line("*cls", 1'b1, 1);
    expect_cmd("cls", mk(KW_CLS, 1'b0, 1'b1, 1'b0, 8'h01, 4'h0, SP_NONE));
    line("*ESE 253;*ESR?\n", 1'b0, -1);
    expect_cmd("ese", mk(KW_ESE, 1'b0, 1'b1, 1'b0, 8'h01, 4'h1, SP_NONE));
    expect_cmd("esr", mk(KW_ESR, 1'b1, 1'b1, 1'b0, 8'h01, 4'h0, SP_NONE));
    expect_bytes("ese_par", "253");
  endtask

  task automatic t_suffix();
    line("OUTP:MARK2 ON\n", 1'b0, -1);
    expect_cmd("mark2", mk(F_MARK_LIST, 1'b0, 1'b0, 1'b0, 8'h02, 4'h1, SP_NONE));
    expect_bytes("mark2_par", "ON");
    line("OUTP:I:STAT\t1\n", 1'b0, -1);
    expect_cmd("istat", mk(F_I_STATE, 1'b0, 1'b0, 1'b0, 8'h01, 4'h1, SP_NONE));
    line("mark:list 1,,2\n", 1'b0, -1);
    expect_cmd("list", mk(F_MARK_LIST, 1'b0, 1'b0, 1'b0, 8'h01, 4'h3, SP_NONE));
    expect_bytes("list_par", "12");
    `CHK("list_idx0", 4'h0, iq[0])
    `CHK("list_idx1", 4'h2, iq[1])
    line("MARKER3 1\n", 1'b0, -1);
    expect_cmd("marker3", mk(F_MARK_LIST, 1'b0, 1'b0, 1'b0, 8'h03, 4'h1, SP_NONE));
  endtask

  task automatic t_levels();
    line("MMEM:DATA:LENG?\n", 1'b0, -1);
    expect_cmd("dlen", mk(F_DATA_LEN, 1'b1, 1'b0, 1'b0, 8'h01, 4'h0, SP_NONE));
    line("mmemory:dcatalog:length?\n", 1'b0, -1);
    expect_cmd("clen", mk(F_DCAT_LEN, 1'b1, 1'b0, 1'b0, 8'h01, 4'h0, SP_NONE));
    line("CLOC 5\n", 1'b0, -1);
    expect_cmd("cloc", mk(F_CLOCK, 1'b0, 1'b0, 1'b0, 8'h01, 4'h1, SP_NONE));
    line("OUTP:MARKE 1\n", 1'b0, -1);
    expect_cmd("trunc", mk(F_NONE, 1'b0, 1'b0, 1'b1, 8'h01, 4'h0, SP_NONE));
    line("FOO 1;*OPC\n", 1'b0, -1);
    expect_cmd("foo", mk(F_NONE, 1'b0, 1'b0, 1'b1, 8'h01, 4'h0, SP_NONE));
    expect_cmd("opc", mk(KW_OPC, 1'b0, 1'b1, 1'b0, 8'h01, 4'h0, SP_NONE));
  endtask

  task automatic t_path();
    line("MMEM:MSIS 'C:';LOAD RAM\n", 1'b0, -1);
    expect_cmd("msis", mk(F_MSIS, 1'b0, 1'b0, 1'b0, 8'h01, 4'h1, SP_NONE));
    expect_cmd("load", mk(F_LOAD, 1'b0, 1'b0, 1'b0, 8'h01, 4'h1, SP_NONE));
    expect_bytes("path_par", "'C:'RAM");
    line("LOAD RAM\n", 1'b0, -1);
    expect_cmd("fresh", mk(F_NONE, 1'b0, 1'b0, 1'b1, 8'h01, 4'h0, SP_NONE));
    line("OUTP:I 1;:CLOC 5\n", 1'b0, -1);
    expect_cmd("imode", mk(F_I_MODE, 1'b0, 1'b0, 1'b0, 8'h01, 4'h1, SP_NONE));
    expect_cmd("root", mk(F_CLOCK, 1'b0, 1'b0, 1'b0, 8'h01, 4'h1, SP_NONE));
    line("OUTP:I 1;FILT EXT\n", 1'b0, -1);
    expect_cmd("imode2", mk(F_I_MODE, 1'b0, 1'b0, 1'b0, 8'h01, 4'h1, SP_NONE));
    expect_cmd("filt", mk(F_FILTER, 1'b0, 1'b0, 1'b0, 8'h01, 4'h1, SP_NONE));
  endtask

  task automatic t_special();
    string w[3] = '{"MIN", "MAXIMUM", "DEF"};
    for (int i = 0; i < 3; i++) begin
      line({"OUTP:I:AMPL? ", w[i], "\n"}, 1'b0, -1);
      expect_cmd("spec", mk(F_I_AMPL, 1'b1, 1'b0, 1'b0, 8'h01, 4'h1, 2'(i + 1)));
    end
  endtask

  // Paths, codes and byte kinds the other scenarios leave out
  task automatic t_misc();
    line("syst:beeper:stat ON\n", 1'b0, -1);
    expect_cmd("beep", mk(F_BEEP_STATE, 1'b0, 1'b0, 1'b0, 8'h01, 4'h1, SP_NONE));
    line("*IDN?\n", 1'b0, -1);
    expect_cmd("idn", mk(KW_IDN, 1'b1, 1'b1, 1'b0, 8'h01, 4'h0, SP_NONE));
    line("OUTP:I \200\n", 1'b0, -1);
    expect_cmd("nonascii", mk(F_NONE, 1'b0, 1'b0, 1'b1, 8'h01, 4'h0, SP_NONE));
    line("MMEM 1\n", 1'b0, -1);
    expect_cmd("prefix", mk(F_NONE, 1'b0, 1'b0, 1'b1, 8'h01, 4'h1, SP_NONE));
    line("OUTP:I 1;", 1'b1, -1);
    expect_cmd("eoi_semi", mk(F_I_MODE, 1'b0, 1'b0, 1'b0, 8'h01, 4'h1, SP_NONE));
    line("FILT EXT\n", 1'b0, -1);
    expect_cmd("eoi_fresh", mk(F_NONE, 1'b0, 1'b0, 1'b1, 8'h01, 4'h0, SP_NONE));
    // Stall while a report stands: it must be counted once
    line("*RST;*CLS\n", 1'b0, 5);
    expect_cmd("rst_hold", mk(KW_RST, 1'b0, 1'b1, 1'b0, 8'h01, 4'h0, SP_NONE));
    expect_cmd("cls_hold", mk(KW_CLS, 1'b0, 1'b1, 1'b0, 8'h01, 4'h0, SP_NONE));
  endtask

  // Reset for six cycles, then walk the scenarios
  initial begin
    rst_i = 1'b1;
    repeat (6) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_i = 1'b0;
    t_common();
    t_suffix();
    t_levels();
    t_path();
    t_special();
    t_misc();
    results();
  end
endmodule
